/* design/usu_pkg.sv */
/*
 * usu_pkg: constants shared by the serial unit control block.
 * Assumes an 8-bit register port and a 100 MHz system clock.
 */
package usu_pkg;

	// ==================================================================
	// register map
	localparam logic [7:0] ADDR_CTRL   = 8'hB8; // serial_unit_control
	localparam logic [7:0] ADDR_STATUS = 8'hB9; // flags and counter
	localparam logic [7:0] ADDR_PORT   = 8'hBA; // pin port values
	localparam logic [7:0] ADDR_DIR    = 8'hBB; // pin directions

	// ==================================================================
	// control register fields
	localparam int CTRL_START_IE  = 7;
	localparam int CTRL_OVF_IE    = 6;
	localparam int CTRL_WM_HI     = 5;
	localparam int CTRL_WM_LO     = 4;
	localparam int CTRL_CS_HI     = 3;
	localparam int CTRL_CS_LO     = 2;
	localparam int CTRL_CLK_STB   = 1;
	localparam int CTRL_TOGGLE    = 0;

	// ==================================================================
	// status register fields
	localparam int STAT_START_FLAG = 7;
	localparam int STAT_OVF_FLAG   = 6;
	localparam int STAT_CNT_HI     = 3;

	// ==================================================================
	// port and direction register fields
	localparam int PIN_DOUT = 0; // data-out pin
	localparam int PIN_DIN  = 1; // data-in / two-wire data pin
	localparam int PIN_SCK  = 2; // serial clock pin

	// ==================================================================
	// reset values and widths
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [3:0] CNT_RESET    = 4'h0;
	localparam logic [3:0] CNT_MAX      = 4'hF;
	localparam logic [2:0] PINS_RESET   = 3'h0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ==================================================================
	// wire modes and clock sources
	typedef enum logic [1:0] {
		WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD
	} usu_wire_mode_type;

	typedef enum logic [1:0] {
		CS_SOFT, CS_TIMER, CS_EXT_POS, CS_EXT_NEG
	} usu_clk_src_type;

endpackage : usu_pkg

/* design/usu_pin_if.sv */
/*
 * usu_pin_if: synchronised pin levels and edges, passed from the
 * pin synchroniser to the control block. Same clock on both sides.
 */
`timescale 1ns/100ps
`default_nettype none

interface usu_pin_if;
	logic scl_lvl;  // synchronised clock pin level
	logic sda_lvl;  // synchronised data-in pin level
	logic scl_rise; // one-cycle pulse
	logic scl_fall; // one-cycle pulse
	logic sda_fall; // one-cycle pulse

	modport sync (output scl_lvl, sda_lvl, scl_rise, scl_fall, sda_fall);
	modport user (input  scl_lvl, sda_lvl, scl_rise, scl_fall, sda_fall);
endinterface : usu_pin_if

`default_nettype wire

/* design/usu_pin_sync.sv */
/*
 * usu_pin_sync: two-flop synchronisers and edge detectors for the
 * serial clock pin and the data-in pin.
 * Assumes pin levels arrive asynchronously to i_clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module usu_pin_sync (
	input  wire logic i_clk_sys, // system clock
	input  wire logic i_rst,     // synchronous reset, high
	input  wire logic i_scl_pin, // raw clock pin level
	input  wire logic i_sda_pin, // raw data-in pin level
	usu_pin_if.sync   pins       // synchronised levels and edges
);

	logic [1:0] scl_meta_q;
	logic [1:0] sda_meta_q;
	logic       scl_prev_q;
	logic       sda_prev_q;

	// ==================================================================
	// synchronisers: stage 0 is read only by stage 1; no reset, so
	// every stage already holds the idle pin level when reset ends
	// and no false edge follows the release
	always_ff @(posedge i_clk_sys) begin
		scl_meta_q <= {scl_meta_q[0], i_scl_pin};
		sda_meta_q <= {sda_meta_q[0], i_sda_pin};
		scl_prev_q <= scl_meta_q[1];
		sda_prev_q <= sda_meta_q[1];
	end

	// edges compare the settled stage with one cycle older; masked
	// during reset while the stages may still be filling
	assign pins.scl_lvl  = scl_meta_q[1];
	assign pins.sda_lvl  = sda_meta_q[1];
	assign pins.scl_rise = scl_meta_q[1] & ~scl_prev_q & ~i_rst;
	assign pins.scl_fall = ~scl_meta_q[1] & scl_prev_q & ~i_rst;
	assign pins.sda_fall = ~sda_meta_q[1] & sda_prev_q & ~i_rst;

endmodule : usu_pin_sync

`default_nettype wire

/* design/usu_control.sv */
/*
 * usu_control: control side of a universal serial unit - transfer
 * counter, clock source selection, interrupt enables, wire modes,
 * start and overflow clock holds, and pin drive for three pins.
 * Assumes a register master on the same clock, a shift register
 * outside this block (its MSB comes in, its shift tick goes out),
 * and a wire-level bus model that resolves the open-drain enables.
 */
// The plain strobed port was left to the implementer.
// What this block does
// - counter readable and writable by software at any time
// - counter steps once per tick from selected clock source
// - external source plus clock strobe set: toggle strobe writes tick
// - external clock pin ticks the counter even with outputs off
// - control register layout as listed, all bits reset to zero
// - start enable passes a pending start flag out at once
// - overflow enable passes a pending overflow flag out at once
// - wire mode affects outputs and the start detector; inputs always keep working
// - wire mode zero: outputs and hold off, any pin clock edge sets start flag when the pin clocks the counter; plain port
// - three-wire: shift output replaces port on data-out pin
// - two-wire: data and clock open drain, enabled by direction bits
// - two-wire data pulled low if shift output or port bit zero
// - two-wire clock pulled low if port bit zero or start hold
// - start seen with clock driver on holds clock until flag cleared
// - two-wire disables pull-ups on data and clock pins
// - second two-wire mode also holds clock after counter overflow
// - overflow flag set when counter wraps from fifteen to zero
// - start flag cleared only by writing one; zero leaves it
// - clock source zero: clock strobe write ticks shift and counter
// - toggle strobe inverts clock port value regardless of direction
`timescale 1ns/100ps
`default_nettype none

module usu_control (
	input  wire logic       i_clk_sys,     // system clock, 100 MHz
	input  wire logic       i_rst,         // synchronous reset, high
	input  wire logic [7:0] i_addr,        // register address
	input  wire logic [7:0] i_wdata,       // register write data
	input  wire logic       i_wr,          // write strobe
	input  wire logic       i_rd,          // read strobe
	output logic      [7:0] o_rdata,       // read data, cycle after
	input  wire logic       i_global_ie,   // global interrupt enable
	input  wire logic       i_timer_match, // timer compare pulse
	input  wire logic       i_shift_msb,   // shift register bit 7
	input  wire logic       i_scl_pin,     // clock pin level
	input  wire logic       i_sda_pin,     // data-in pin level
	output logic            o_shift_tick,  // shift register clock
	output logic            o_start_irq,   // start interrupt request
	output logic            o_ovf_irq,     // overflow interrupt req
	output logic            o_dout_o,      // data-out pin value
	output logic            o_dout_oe,     // data-out pin enable
	output logic            o_dout_pu,     // data-out pin pull-up
	output logic            o_sda_o,       // data pin value
	output logic            o_sda_oe,      // data pin enable
	output logic            o_sda_pu,      // data pin pull-up
	output logic            o_scl_o,       // clock pin value
	output logic            o_scl_oe,      // clock pin enable
	output logic            o_scl_pu       // clock pin pull-up
);

	// ==================================================================
	// pin synchroniser
	usu_pin_if pins ();

	usu_pin_sync u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_scl_pin (i_scl_pin),
		.i_sda_pin (i_sda_pin),
		.pins      (pins)
	);

	// ==================================================================
	// state
	logic                       start_ie_q;
	logic                       ovf_ie_q;
	usu_pkg::usu_wire_mode_type wire_mode_q;
	usu_pkg::usu_clk_src_type   clk_src_q;
	logic                       clk_sel_q;
	logic [3:0]                 cnt_q;
	logic [3:0]                 cnt_d;
	logic                       start_flag_q;
	logic                       ovf_flag_q;
	logic [2:0]                 port_q;
	logic [2:0]                 dir_q;

	// ==================================================================
	// register decode
	logic wr_ctrl;
	logic wr_status;
	logic wr_port;
	logic wr_dir;
	logic clk_strobe_wr;
	logic toggle_wr;

	assign wr_ctrl   = i_wr && (i_addr == usu_pkg::ADDR_CTRL);
	assign wr_status = i_wr && (i_addr == usu_pkg::ADDR_STATUS);
	assign wr_port   = i_wr && (i_addr == usu_pkg::ADDR_PORT);
	assign wr_dir    = i_wr && (i_addr == usu_pkg::ADDR_DIR);

	// strobes act only in the cycle of the write itself
	assign clk_strobe_wr = wr_ctrl && i_wdata[usu_pkg::CTRL_CLK_STB];
	assign toggle_wr     = wr_ctrl && i_wdata[usu_pkg::CTRL_TOGGLE];

	// ==================================================================
	// mode decode
	logic two_wire;
	logic ext_src;

	assign two_wire = (wire_mode_q == usu_pkg::WM_TWO) ||
		(wire_mode_q == usu_pkg::WM_TWO_HOLD);
	assign ext_src  = (clk_src_q == usu_pkg::CS_EXT_POS) ||
		(clk_src_q == usu_pkg::CS_EXT_NEG);

	// ==================================================================
	// counter clock source; the clock pin is read in every wire mode
	// because the synchroniser sits before any mode gating
	logic cnt_tick;

	always_comb begin
		cnt_tick = 1'b0;
		case (clk_src_q)
			usu_pkg::CS_SOFT: begin
				cnt_tick = clk_strobe_wr;
			end
			usu_pkg::CS_TIMER: begin
				cnt_tick = i_timer_match;
			end
			usu_pkg::CS_EXT_POS, usu_pkg::CS_EXT_NEG: begin
				if (clk_sel_q) begin
					cnt_tick = toggle_wr;
				end else begin
					cnt_tick = pins.scl_rise | pins.scl_fall;
				end
			end
			default: begin
				cnt_tick = 1'b0;
			end
		endcase
	end

	// ==================================================================
	// shift register clock: one edge only for external sources
	logic shift_tick;

	always_comb begin
		shift_tick = 1'b0;
		case (clk_src_q)
			usu_pkg::CS_SOFT: begin
				shift_tick = clk_strobe_wr;
			end
			usu_pkg::CS_TIMER: begin
				shift_tick = i_timer_match;
			end
			usu_pkg::CS_EXT_POS: begin
				shift_tick = pins.scl_rise;
			end
			usu_pkg::CS_EXT_NEG: begin
				shift_tick = pins.scl_fall;
			end
			default: begin
				shift_tick = 1'b0;
			end
		endcase
	end

	// ==================================================================
	// control register; clock strobe bit is kept as the select
	// for external sources but always reads back as zero
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			start_ie_q  <= usu_pkg::CTRL_RESET[usu_pkg::CTRL_START_IE];
			ovf_ie_q    <= usu_pkg::CTRL_RESET[usu_pkg::CTRL_OVF_IE];
			wire_mode_q <= usu_pkg::WM_OFF;
			clk_src_q   <= usu_pkg::CS_SOFT;
			clk_sel_q   <= usu_pkg::CTRL_RESET[usu_pkg::CTRL_CLK_STB];
		end else if (wr_ctrl) begin
			start_ie_q  <= i_wdata[usu_pkg::CTRL_START_IE];
			ovf_ie_q    <= i_wdata[usu_pkg::CTRL_OVF_IE];
			wire_mode_q <= usu_pkg::usu_wire_mode_type'(
				i_wdata[usu_pkg::CTRL_WM_HI:usu_pkg::CTRL_WM_LO]);
			clk_src_q   <= usu_pkg::usu_clk_src_type'(
				i_wdata[usu_pkg::CTRL_CS_HI:usu_pkg::CTRL_CS_LO]);
			clk_sel_q   <= i_wdata[usu_pkg::CTRL_CLK_STB];
		end
	end

	// ==================================================================
	// transfer counter: a software write wins over a tick
	always_comb begin
		cnt_d = cnt_q;
		if (wr_status) begin
			cnt_d = i_wdata[usu_pkg::STAT_CNT_HI:0];
		end else if (cnt_tick) begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cnt_q <= usu_pkg::CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ==================================================================
	// overflow flag: set on wrap, write one clears, a status write blocks the set
	logic ovf_set;

	assign ovf_set = !wr_status && cnt_tick &&
		(cnt_q == usu_pkg::CNT_MAX);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ovf_flag_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_flag_q <= 1'b1;
		end else if (wr_status && i_wdata[usu_pkg::STAT_OVF_FLAG]) begin
			ovf_flag_q <= 1'b0;
		end
	end

	// ==================================================================
	// start detector: data falls while clock is high, two-wire only;
	// outside two-wire any clock edge sets it when the pin clocks
	logic start_set;

	always_comb begin
		start_set = 1'b0;
		if (two_wire) begin
			start_set = pins.sda_fall && pins.scl_lvl;
		end else if (ext_src && !clk_sel_q) begin
			start_set = pins.scl_rise | pins.scl_fall;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			start_flag_q <= 1'b0;
		end else if (start_set) begin
			start_flag_q <= 1'b1;
		end else if (wr_status &&
				i_wdata[usu_pkg::STAT_START_FLAG]) begin
			start_flag_q <= 1'b0;
		end
	end

	// ==================================================================
	// port and direction registers; the toggle strobe flips the
	// clock port bit whatever its direction, a port write in the
	// same cycle as a toggle takes the toggled written value
	logic [2:0] port_wval;

	always_comb begin
		port_wval = wr_port ? i_wdata[2:0] : port_q;
		if (toggle_wr) begin
			port_wval[usu_pkg::PIN_SCK] = ~port_wval[usu_pkg::PIN_SCK];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			port_q <= usu_pkg::PINS_RESET;
		end else begin
			port_q <= port_wval;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			dir_q <= usu_pkg::PINS_RESET;
		end else if (wr_dir) begin
			dir_q <= i_wdata[2:0];
		end
	end

	// ==================================================================
	// clock holds: start hold in both two-wire modes, overflow hold
	// only in the second one; clearing the flag releases the line
	logic start_hold;
	logic ovf_hold;
	logic scl_low;
	logic sda_low;

	assign start_hold = two_wire && start_flag_q;
	assign ovf_hold   = (wire_mode_q == usu_pkg::WM_TWO_HOLD) &&
		ovf_flag_q;
	assign scl_low    = !port_q[usu_pkg::PIN_SCK] ||
		start_hold || ovf_hold;
	assign sda_low    = !i_shift_msb || !port_q[usu_pkg::PIN_DIN];

	// ==================================================================
	// pin drive, registered so that every output comes from a flop
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_dout_o  <= 1'b0;
			o_dout_oe <= 1'b0;
			o_dout_pu <= 1'b0;
			o_sda_o   <= 1'b0;
			o_sda_oe  <= 1'b0;
			o_sda_pu  <= 1'b0;
			o_scl_o   <= 1'b0;
			o_scl_oe  <= 1'b0;
			o_scl_pu  <= 1'b0;
		end else begin
			case (wire_mode_q)
				usu_pkg::WM_THREE: begin
					// shift MSB overrides port value, direction still rules
					o_dout_o  <= i_shift_msb;
					o_dout_oe <= dir_q[usu_pkg::PIN_DOUT];
					o_dout_pu <= !dir_q[usu_pkg::PIN_DOUT] &&
						port_q[usu_pkg::PIN_DOUT];
					o_sda_o   <= port_q[usu_pkg::PIN_DIN];
					o_sda_oe  <= dir_q[usu_pkg::PIN_DIN];
					o_sda_pu  <= !dir_q[usu_pkg::PIN_DIN] &&
						port_q[usu_pkg::PIN_DIN];
					o_scl_o   <= port_q[usu_pkg::PIN_SCK];
					o_scl_oe  <= dir_q[usu_pkg::PIN_SCK];
					o_scl_pu  <= !dir_q[usu_pkg::PIN_SCK] &&
						port_q[usu_pkg::PIN_SCK];
				end
				usu_pkg::WM_TWO, usu_pkg::WM_TWO_HOLD: begin
					// data and clock open drain: only ever drive low, never pull up; data-out stays a plain port pin
					o_dout_o  <= port_q[usu_pkg::PIN_DOUT];
					o_dout_oe <= dir_q[usu_pkg::PIN_DOUT];
					o_dout_pu <= !dir_q[usu_pkg::PIN_DOUT] &&
						port_q[usu_pkg::PIN_DOUT];
					o_sda_o   <= 1'b0;
					o_sda_oe  <= dir_q[usu_pkg::PIN_DIN] && sda_low;
					o_sda_pu  <= 1'b0;
					o_scl_o   <= 1'b0;
					o_scl_oe  <= dir_q[usu_pkg::PIN_SCK] && scl_low;
					o_scl_pu  <= 1'b0;
				end
				default: begin
					// outputs off: all three are plain port pins
					o_dout_o  <= port_q[usu_pkg::PIN_DOUT];
					o_dout_oe <= dir_q[usu_pkg::PIN_DOUT];
					o_dout_pu <= !dir_q[usu_pkg::PIN_DOUT] &&
						port_q[usu_pkg::PIN_DOUT];
					o_sda_o   <= port_q[usu_pkg::PIN_DIN];
					o_sda_oe  <= dir_q[usu_pkg::PIN_DIN];
					o_sda_pu  <= !dir_q[usu_pkg::PIN_DIN] &&
						port_q[usu_pkg::PIN_DIN];
					o_scl_o   <= port_q[usu_pkg::PIN_SCK];
					o_scl_oe  <= dir_q[usu_pkg::PIN_SCK];
					o_scl_pu  <= !dir_q[usu_pkg::PIN_SCK] &&
						port_q[usu_pkg::PIN_SCK];
				end
			endcase
		end
	end

	// ==================================================================
	// shift tick and interrupt requests; a pending flag goes out as
	// soon as its enable and the global enable are both high
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_shift_tick <= 1'b0;
			o_start_irq  <= 1'b0;
			o_ovf_irq    <= 1'b0;
		end else begin
			o_shift_tick <= shift_tick;
			o_start_irq  <= start_flag_q && start_ie_q && i_global_ie;
			o_ovf_irq    <= ovf_flag_q && ovf_ie_q && i_global_ie;
		end
	end

	// ==================================================================
	// read path: data stand only in the cycle after the strobe
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = usu_pkg::READ_UNMAPPED;
		case (i_addr)
			usu_pkg::ADDR_CTRL: begin
				// strobe bits always read back as zero
				rd_mux = {start_ie_q, ovf_ie_q, wire_mode_q,
					clk_src_q, 2'h0};
			end
			usu_pkg::ADDR_STATUS: begin
				rd_mux = {start_flag_q, ovf_flag_q, 2'h0, cnt_q};
			end
			usu_pkg::ADDR_PORT: begin
				rd_mux = {5'h00, port_q};
			end
			usu_pkg::ADDR_DIR: begin
				rd_mux = {5'h00, dir_q};
			end
			default: begin
				rd_mux = usu_pkg::READ_UNMAPPED;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rdata <= usu_pkg::READ_UNMAPPED;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end else begin
			o_rdata <= usu_pkg::READ_UNMAPPED;
		end
	end

endmodule : usu_control

`default_nettype wire

/* verification/usu_control_props.sv */
/* usu_control_props: port assertions for usu_control.
   Assumes bind to the top; control and direction are shadowed. */
`timescale 1ns/100ps
`default_nettype none

module usu_control_props (
	input wire logic       i_clk_sys,     // clock
	input wire logic       i_rst,         // reset
	input wire logic [7:0] i_addr,        // address
	input wire logic [7:0] i_wdata,       // write data
	input wire logic       i_wr,          // write
	input wire logic       i_rd,          // read
	input wire logic [7:0] o_rdata,       // read data
	input wire logic       i_global_ie,   // global enable
	input wire logic       i_timer_match, // timer pulse
	input wire logic       i_shift_msb,   // shift msb
	input wire logic       o_shift_tick,  // shift tick
	input wire logic       o_start_irq,   // start irq
	input wire logic       o_ovf_irq,     // overflow irq
	input wire logic       o_sda_o,       // data value
	input wire logic       o_sda_oe,      // data enable
	input wire logic       o_sda_pu,      // data pull-up
	input wire logic       o_scl_o,       // clock value
	input wire logic       o_scl_pu       // clock pull-up
);
	logic [7:0] ctrl_q; // shadow control
	logic [2:0] dir_q;  // shadow direction

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ==================================================================
	// shadows: outputs depend on mode, which the ports do not show
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			ctrl_q <= 8'h00;
		else if (i_wr && i_addr == usu_pkg::ADDR_CTRL)
			ctrl_q <= i_wdata;
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			dir_q <= 3'h0;
		else if (i_wr && i_addr == usu_pkg::ADDR_DIR)
			dir_q <= i_wdata[2:0];
	end

	// ==================================================================
	// properties
	sequence s_cnt_wr;
		i_wr && i_addr == usu_pkg::ADDR_STATUS;
	endsequence
	sequence s_cnt_rd;
		i_rd && i_addr == usu_pkg::ADDR_STATUS;
	endsequence

	a_cnt_write_wins: assert property (s_cnt_wr ##1 s_cnt_rd
		|=> o_rdata[3:0] == $past(i_wdata[3:0], 2))
		else $error("counter write not read back");
	a_ctrl_read_back: assert property (i_rd && i_addr == usu_pkg::ADDR_CTRL
		|=> o_rdata == {$past(ctrl_q[7:2]), 2'h0})
		else $error("control read mismatch");
	a_start_irq_gate: assert property ((!i_global_ie || !ctrl_q[7])
		|=> !o_start_irq) else $error("start irq not gated");
	a_ovf_irq_gate: assert property ((!i_global_ie || !ctrl_q[6])
		|=> !o_ovf_irq) else $error("overflow irq not gated");
	a_timer_tick_out: assert property (i_timer_match && ctrl_q[3:2] == 2'h1
		|=> o_shift_tick) else $error("timer tick missing");
	a_soft_tick_out: assert property (i_wr && i_addr == usu_pkg::ADDR_CTRL
		&& i_wdata[3:1] == 3'h1 && ctrl_q[3:2] == 2'h0 |=> o_shift_tick)
		else $error("strobe tick missing");
	a_two_wire_pulls: assert property ($past(ctrl_q[5]) && !$past(i_rst)
		|-> !o_sda_pu && !o_scl_pu) else $error("pull-up on in two-wire");
	a_two_wire_od: assert property ($past(ctrl_q[5]) && !$past(i_rst)
		|-> !o_sda_o && !o_scl_o) else $error("two-wire drives high");
	a_sda_pull_low: assert property ($past(ctrl_q[5] && dir_q[1])
		&& !$past(i_shift_msb) && !$past(i_rst) |-> o_sda_oe)
		else $error("data not pulled low");
	a_sda_no_dir: assert property ($past(ctrl_q[5] && !dir_q[1])
		&& !$past(i_rst) |-> !o_sda_oe) else $error("data driven without dir");
endmodule : usu_control_props

bind usu_control usu_control_props props_u (.*);

`default_nettype wire

/* verification/usu_peer.sv */
/* usu_peer: serial bus master at the far side of the pins.
   Assumes released lines rise through bus pull-ups. */
`timescale 1ns/100ps
`default_nettype none

module usu_peer (
	input  wire logic i_scl_o,   // block clock value
	input  wire logic i_scl_oe,  // block clock enable
	input  wire logic i_sda_o,   // block data value
	input  wire logic i_sda_oe,  // block data enable
	output logic      o_scl_pin, // resolved clock line
	output logic      o_sda_pin  // resolved data line
);
	logic scl_q = 1'h1; // own clock, idle released
	logic sda_q = 1'h1; // own data, idle released

	// ==================================================================
	// line resolution: a holding block wins over the released peer
	assign o_scl_pin = i_scl_oe ? i_scl_o : scl_q;
	assign o_sda_pin = i_sda_oe ? i_sda_o : sda_q;

	// clock stands still outside frames; half sets prompt or slow
	task automatic clocks(input int n, input realtime half);
		repeat (n) begin
			#(half) scl_q = 1'h0;
			#(half) scl_q = 1'h1;
		end
	endtask : clocks

	// data falls while the clock is high, then clock falls
	task automatic start_cond(input realtime half);
		sda_q = 1'h0;
		#(half) scl_q = 1'h0;
		#(half) sda_q = 1'h1;
	endtask : start_cond
endmodule : usu_peer

`default_nettype wire

/* verification/usu_control_tb_top.sv */
/* usu_control_tb_top: register-level bench for usu_control.
   Assumes the peer model resolves clock and data lines. */
`timescale 1ns/100ps
`default_nettype none

module usu_control_tb_top;
	logic       i_clk_sys = 1'h0;
	logic       i_rst = 1'h1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'h0;
	logic       i_rd = 1'h0;
	logic       i_global_ie = 1'h0;
	logic       i_timer_match = 1'h0;
	logic       i_shift_msb = 1'h1;
	wire        i_scl_pin;
	wire        i_sda_pin;
	logic [7:0] o_rdata;
	logic       o_shift_tick, o_start_irq, o_ovf_irq;
	logic       o_dout_o, o_dout_oe, o_dout_pu;
	logic       o_sda_o, o_sda_oe, o_sda_pu;
	logic       o_scl_o, o_scl_oe, o_scl_pu;
	int         n_fail = 0;
	int         compares = 0;
	int         n_tick = 0;
	int         tick_base = 0;

	always #5 i_clk_sys = ~i_clk_sys;

	// shift ticks counted at each edge, where the pulse has settled
	always @(posedge i_clk_sys) begin
		if (o_shift_tick)
			n_tick++;
	end

	usu_control dut_u (.*);
	usu_peer peer_u (.i_scl_o(o_scl_o), .i_scl_oe(o_scl_oe),
		.i_sda_o(o_sda_o), .i_sda_oe(o_sda_oe),
		.o_scl_pin(i_scl_pin), .o_sda_pin(i_sda_pin));

	// ==================================================================
	// bus and check tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'h0;
	endtask : wr

	// write then read the same place with no gap
	task automatic wrc(input logic [7:0] a, d, e);
		wr(a, d);
		i_rd <= 1'h1;
		@(posedge i_clk_sys);
		i_rd <= 1'h0;
		#1 chk(o_rdata, e);
	endtask : wrc

	task automatic rdc(input logic [7:0] a, e);
		@(posedge i_clk_sys);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'h0;
		#1 chk(o_rdata, e);
	endtask : rdc

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : settle

	task automatic final_report;
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (50000) @(posedge i_clk_sys);
		n_fail++;
		final_report();
	end

	// ==================================================================
	// main sequence
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rst <= 1'h0;
		rdc(usu_pkg::ADDR_CTRL, 8'h00);
		rdc(usu_pkg::ADDR_STATUS, 8'h00);
		rdc(8'hBC, usu_pkg::READ_UNMAPPED);
		wrc(usu_pkg::ADDR_CTRL, 8'hFC, 8'hFC);
		wr(usu_pkg::ADDR_CTRL, 8'h00);
		// software strobe wraps the counter
		wrc(usu_pkg::ADDR_STATUS, 8'h0E, 8'h0E);
		wr(usu_pkg::ADDR_CTRL, 8'h02);
		wr(usu_pkg::ADDR_CTRL, 8'h02);
		rdc(usu_pkg::ADDR_STATUS, 8'h40);
		wrc(usu_pkg::ADDR_STATUS, 8'h00, 8'h40);
		@(posedge i_clk_sys) i_global_ie <= 1'h1;
		wr(usu_pkg::ADDR_CTRL, 8'h40);
		settle(2);
		chk(o_ovf_irq, 8'h01);
		@(posedge i_clk_sys) i_global_ie <= 1'h0;
		settle(2);
		chk(o_ovf_irq, 8'h00);
		@(posedge i_clk_sys) i_global_ie <= 1'h1;
		wrc(usu_pkg::ADDR_STATUS, 8'h40, 8'h00);
		// timer source, three back-to-back matches
		wr(usu_pkg::ADDR_CTRL, 8'h04);
		@(posedge i_clk_sys) i_timer_match <= 1'h1;
		repeat (3) @(posedge i_clk_sys);
		i_timer_match <= 1'h0;
		rdc(usu_pkg::ADDR_STATUS, 8'h03);
		// toggle strobe as counter clock and clock port flip
		wr(usu_pkg::ADDR_CTRL, 8'h0A);
		wr(usu_pkg::ADDR_CTRL, 8'h0B);
		rdc(usu_pkg::ADDR_STATUS, 8'h04);
		rdc(usu_pkg::ADDR_PORT, 8'h04);
		// outputs off, pin clock still counts, prompt and slow peer
		wrc(usu_pkg::ADDR_CTRL, 8'h08, 8'h08);
		wr(usu_pkg::ADDR_STATUS, 8'h00);
		// pin changes kept off the sampling edge of the system clock
		#1 tick_base = n_tick;
		peer_u.clocks(2, 62.5);
		peer_u.clocks(1, 200.0);
		settle(6);
		chk(8'(n_tick - tick_base), 8'h03);
		rdc(usu_pkg::ADDR_STATUS, 8'h86);
		wrc(usu_pkg::ADDR_STATUS, 8'h80, 8'h00);
		// two-wire: open drain, start hold
		wr(usu_pkg::ADDR_CTRL, 8'hA8);
		wr(usu_pkg::ADDR_PORT, 8'h06);
		wr(usu_pkg::ADDR_DIR, 8'h06);
		settle(2);
		chk(o_sda_oe, 8'h00);
		chk(o_scl_oe, 8'h00);
		peer_u.start_cond(62.5);
		settle(6);
		chk(o_scl_oe, 8'h01);
		chk(o_start_irq, 8'h01);
		rdc(usu_pkg::ADDR_STATUS, 8'h81);
		// data pulled low only while the clock is held, so that the
		// block's own drive is not taken for a start condition
		@(posedge i_clk_sys) i_shift_msb <= 1'h0;
		settle(2);
		chk(o_sda_oe, 8'h01);
		@(posedge i_clk_sys) i_shift_msb <= 1'h1;
		wrc(usu_pkg::ADDR_STATUS, 8'h80, 8'h00);
		settle(2);
		chk(o_scl_oe, 8'h00);
		// second two-wire mode: overflow hold
		wr(usu_pkg::ADDR_CTRL, 8'h38);
		wrc(usu_pkg::ADDR_STATUS, 8'h0F, 8'h0F);
		peer_u.clocks(1, 62.5);
		settle(6);
		chk(o_scl_oe, 8'h01);
		wr(usu_pkg::ADDR_STATUS, 8'h40);
		settle(2);
		chk(o_scl_oe, 8'h00);
		// three-wire: shift bit replaces the data-out port
		wr(usu_pkg::ADDR_CTRL, 8'h10);
		wr(usu_pkg::ADDR_DIR, 8'h01);
		@(posedge i_clk_sys) i_shift_msb <= 1'h0;
		settle(2);
		chk({o_dout_oe, o_dout_o}, 8'h02);
		@(posedge i_clk_sys) i_shift_msb <= 1'h1;
		settle(2);
		chk(o_dout_o, 8'h01);
		wr(usu_pkg::ADDR_CTRL, 8'h11);
		rdc(usu_pkg::ADDR_PORT, 8'h02);
		final_report();
	end
endmodule : usu_control_tb_top

`default_nettype wire
